// file: logic/i2m_master.sv
// Byte-level master for a shared open-drain two-wire bus.
// Assumes pads resolve the wired-AND from the *_oe outputs.
`timescale 1ns/1ps

module i2m_master (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire i2m_pkg::i2m_cmd_s cmd,
   output logic cmd_ready,
   output logic rsp_valid,
   output i2m_pkg::i2m_rsp_s rsp,
   output logic bus_busy,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);

   // ----------------------------------------------------------------
   // Line sampling and phase timer
   // ----------------------------------------------------------------
   logic scl_s;
   logic sda_s;
   logic sda_prev_q;
   logic run;
   logic adv;
   logic take;
   logic eff_start;
   logic refuse;
   logic bit_val;
   logic tx_bit;
   logic lost;
   logic last_bit;
   logic start_seen;

   i2m_pkg::i2m_state_e state_q;
   i2m_pkg::i2m_state_e state_d;
   i2m_pkg::i2m_cmd_s cmd_q;
   logic [7:0] shift_q;
   logic [7:0] rx_q;
   logic [3:0] bit_q;
   logic nack_q;
   logic scl_oe_q;
   logic sda_oe_q;
   logic cmd_ready_q;
   logic rsp_valid_q;
   i2m_pkg::i2m_rsp_s rsp_q;
   logic busy_q;

   i2m_sync #(
      .W(2)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d({scl_i, sda_i}),
      .q({scl_s, sda_s})
   );

   // Count a phase only once the line really shows it, so a slave
   // stretching SCL low simply delays the high phase.
   assign run = scl_oe_q ? !scl_s : scl_s;

   i2m_timer u_timer (
      .clk(clk),
      .reset_n(reset_n),
      .clr(adv || take),
      .run(run),
      .done(adv)
   );

   // ----------------------------------------------------------------
   // Command decode and bit values
   // ----------------------------------------------------------------
   assign take = cmd_valid && cmd_ready_q;
   // Off the bus, every byte is an address and opens with START
   assign eff_start = cmd.start || (state_q == i2m_pkg::S_IDLE);
   assign refuse = eff_start &&
      ((cmd.data == i2m_pkg::GEN_CALL_RD) ||
       (cmd.data[7:4] == i2m_pkg::RSVD_HI));
   assign last_bit = (bit_q == i2m_pkg::BIT_ACK);
   // Receiver acks unless this is its final byte
   assign bit_val = last_bit ?
      (!cmd_q.read || cmd_q.last || cmd_q.stop) :
      (cmd_q.read || shift_q[7]);
   assign tx_bit = last_bit ? cmd_q.read : !cmd_q.read;
   assign lost = !sda_oe_q && !sda_s && tx_bit;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         i2m_pkg::S_IDLE: begin
            if (take && !refuse) begin
               state_d = i2m_pkg::S_RS_SCL;
            end
         end
         i2m_pkg::S_HOLD: begin
            if (take && !refuse) begin
               state_d = cmd.start ? i2m_pkg::S_RS_SDA
                                   : i2m_pkg::S_BIT_LOW;
            end
         end
         i2m_pkg::S_RS_SDA: begin
            if (adv) begin
               state_d = i2m_pkg::S_RS_SCL;
            end
         end
         i2m_pkg::S_RS_SCL: begin
            if (adv) begin
               // Someone else holds SDA: give up before starting
               state_d = sda_s ? i2m_pkg::S_ST_SDA : i2m_pkg::S_IDLE;
            end
         end
         i2m_pkg::S_ST_SDA: begin
            if (adv) begin
               state_d = i2m_pkg::S_BIT_LOW;
            end
         end
         i2m_pkg::S_BIT_LOW: begin
            if (adv) begin
               state_d = i2m_pkg::S_BIT_HIGH;
            end
         end
         i2m_pkg::S_BIT_HIGH: begin
            if (adv) begin
               if (lost) begin
                  state_d = i2m_pkg::S_IDLE;
               end else if (!last_bit) begin
                  state_d = i2m_pkg::S_BIT_LOW;
               end else if (cmd_q.stop) begin
                  state_d = i2m_pkg::S_SP_LOW;
               end else begin
                  state_d = i2m_pkg::S_HOLD;
               end
            end
         end
         i2m_pkg::S_SP_LOW: begin
            if (adv) begin
               state_d = i2m_pkg::S_SP_HIGH;
            end
         end
         i2m_pkg::S_SP_HIGH: begin
            if (adv) begin
               state_d = i2m_pkg::S_SP_SDA;
            end
         end
         i2m_pkg::S_SP_SDA: begin
            if (adv) begin
               state_d = i2m_pkg::S_IDLE;
            end
         end
         default: begin
            state_d = i2m_pkg::S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= i2m_pkg::S_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Line drivers
   // ----------------------------------------------------------------
   // Pads only ever pull low; the level comes from the enables
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_oe_q <= 1'b0;
      end else if (adv) begin
         unique case (state_q)
            i2m_pkg::S_ST_SDA: scl_oe_q <= 1'b1;
            i2m_pkg::S_BIT_HIGH: scl_oe_q <= !lost;
            i2m_pkg::S_BIT_LOW,
            i2m_pkg::S_RS_SDA,
            i2m_pkg::S_SP_LOW: scl_oe_q <= 1'b0;
            default: scl_oe_q <= scl_oe_q;
         endcase
      end
   end

   // Data moves only once SCL is seen low; the synchroniser delay
   // gives hold time after our own falling SCL edge.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_oe_q <= 1'b0;
      end else begin
         unique case (state_q)
            // Released only once SCL is seen low; right after a packet
            // the synchronised SCL may still read high for a cycle.
            i2m_pkg::S_RS_SDA: begin
               if (run) begin
                  sda_oe_q <= 1'b0;
               end
            end
            i2m_pkg::S_RS_SCL: begin
               if (adv && sda_s) begin
                  sda_oe_q <= 1'b1;
               end
            end
            i2m_pkg::S_BIT_LOW: begin
               if (run) begin
                  sda_oe_q <= !bit_val;
               end
            end
            i2m_pkg::S_SP_LOW: begin
               if (run) begin
                  sda_oe_q <= 1'b1;
               end
            end
            i2m_pkg::S_SP_HIGH: begin
               if (adv) begin
                  sda_oe_q <= 1'b0;
               end
            end
            default: begin
               sda_oe_q <= sda_oe_q;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Shift path
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_q <= '0;
         shift_q <= '0;
         rx_q <= '0;
         bit_q <= '0;
         nack_q <= 1'b0;
      end else if (take && !refuse) begin
         cmd_q <= cmd;
         shift_q <= cmd.data;
         bit_q <= '0;
      end else if (adv && state_q == i2m_pkg::S_BIT_HIGH) begin
         bit_q <= bit_q + 4'h1;
         if (last_bit) begin
            nack_q <= sda_s;
         end else begin
            rx_q <= {rx_q[6:0], sda_s};
            shift_q <= {shift_q[6:0], 1'b0};
         end
      end
   end

   // ----------------------------------------------------------------
   // Bus state seen on the lines
   // ----------------------------------------------------------------
   assign start_seen = scl_s && sda_prev_q && !sda_s;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_prev_q <= i2m_pkg::SYNC_RST;
         busy_q <= 1'b0;
      end else begin
         sda_prev_q <= sda_s;
         if (start_seen) begin
            busy_q <= 1'b1;
         end else if (scl_s && !sda_prev_q && sda_s) begin
            busy_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // User side
   // ----------------------------------------------------------------
   // Ready drops for a cycle after every take, so commands are
   // spaced at least two cycles apart.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_ready_q <= 1'b0;
      end else begin
         cmd_ready_q <= !take && ((state_d == i2m_pkg::S_HOLD) ||
            (state_d == i2m_pkg::S_IDLE && !busy_q && !start_seen));
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid_q <= 1'b0;
         rsp_q <= '0;
      end else begin
         rsp_valid_q <= 1'b0;
         if (take && refuse) begin
            rsp_valid_q <= 1'b1;
            rsp_q <= '{data: 8'h00, nack: 1'b1, arb_lost: 1'b0,
                       refused: 1'b1};
         end else if (adv && state_q == i2m_pkg::S_RS_SCL && !sda_s) begin
            rsp_valid_q <= 1'b1;
            rsp_q <= '{data: 8'h00, nack: 1'b1, arb_lost: 1'b1,
                       refused: 1'b0};
         end else if (adv && state_q == i2m_pkg::S_BIT_HIGH &&
                      (lost || (last_bit && !cmd_q.stop))) begin
            rsp_valid_q <= 1'b1;
            rsp_q <= '{data: rx_q, nack: sda_s, arb_lost: lost,
                       refused: 1'b0};
         end else if (adv && state_q == i2m_pkg::S_SP_SDA) begin
            rsp_valid_q <= 1'b1;
            rsp_q <= '{data: rx_q, nack: nack_q, arb_lost: 1'b0,
                       refused: 1'b0};
         end
      end
   end

   assign cmd_ready = cmd_ready_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp = rsp_q;
   assign bus_busy = busy_q;
   assign scl_oe = scl_oe_q;
   assign sda_oe = sda_oe_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_start_only_fall: assert property (
      $rose(sda_oe_q) && $past(scl_s) |->
         $past(state_q) == i2m_pkg::S_RS_SCL)
      else $error("SDA pulled low while SCL high outside START");
   a_stop_only_rise: assert property (
      $fell(sda_oe_q) && $past(scl_s) |->
         $past(state_q) == i2m_pkg::S_SP_HIGH)
      else $error("SDA released while SCL high outside STOP");
   a_nine_bit_pkt: assert property (
      state_q != i2m_pkg::S_HOLD ##1 state_q == i2m_pkg::S_HOLD |->
         bit_q == 4'h9)
      else $error("Packet did not end after nine clocks");
   a_msb_first_out: assert property (
      state_q == i2m_pkg::S_BIT_LOW && run && !last_bit &&
         !cmd_q.read |=> sda_oe_q == !$past(shift_q[7]))
      else $error("Transmitted bit is not the top shift bit");
   a_read_releases: assert property (
      state_q == i2m_pkg::S_BIT_LOW && run && !last_bit &&
         cmd_q.read |=> !sda_oe_q)
      else $error("SDA driven while receiving a data bit");
   a_final_nack: assert property (
      state_q == i2m_pkg::S_BIT_LOW && run && last_bit && cmd_q.read |=>
         sda_oe_q == !($past(cmd_q.last) || $past(cmd_q.stop)))
      else $error("Wrong acknowledge from master receiver");
   a_refuse_rsvd: assert property (
      take && refuse |=> rsp_valid_q && rsp_q.refused &&
         $stable(scl_oe_q) && $stable(sda_oe_q))
      else $error("Illegal address reached the bus");
   a_stretch_wait: assert property (
      state_q == i2m_pkg::S_BIT_HIGH && !scl_s |=>
         state_q == i2m_pkg::S_BIT_HIGH)
      else $error("High phase ended while SCL still held low");
   a_arb_release: assert property (
      state_q == i2m_pkg::S_BIT_HIGH && adv && lost |=>
         !sda_oe_q && !scl_oe_q && state_q == i2m_pkg::S_IDLE &&
         rsp_valid_q && rsp_q.arb_lost)
      else $error("Lost arbitration but kept driving");
   a_no_start_busy: assert property (
      take && state_q == i2m_pkg::S_IDLE |-> !busy_q)
      else $error("Took a START while the bus was busy");
   a_hold_keeps_bus: assert property (
      state_q == i2m_pkg::S_HOLD |-> scl_oe_q)
      else $error("Bus released between packets without STOP");

   c_repeated_start: cover property (
      take && cmd.start && state_q == i2m_pkg::S_HOLD);
   c_stop_done: cover property (
      state_q == i2m_pkg::S_SP_SDA ##1 state_q == i2m_pkg::S_IDLE);
   c_arb_lost: cover property (rsp_valid_q && rsp_q.arb_lost);
   c_refused: cover property (rsp_valid_q && rsp_q.refused);

endmodule : i2m_master

// file: logic/i2m_pkg.sv
// Constants and carrier types of the two-wire bus master.
// Assumes a 100 MHz system clock and open-drain pads outside the design.
package i2m_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SCL_HALF_NS = 1250;
   // Least time, so round up
   localparam int unsigned HALF_CYC =
      (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W = 8;
   localparam logic [TMR_W-1:0] HALF_LAST = TMR_W'(HALF_CYC - 1);

   // ----------------------------------------------------------------
   // Packet layout and special addresses
   // ----------------------------------------------------------------
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [7:0] GEN_CALL_RD = 8'h01;
   localparam logic [3:0] RSVD_HI = 4'hF;
   localparam logic SYNC_RST = 1'h1;

   typedef struct packed {
      logic start;
      logic stop;
      logic read;
      logic last;
      logic [7:0] data;
   } i2m_cmd_s;

   typedef struct packed {
      logic [7:0] data;
      logic nack;
      logic arb_lost;
      logic refused;
   } i2m_rsp_s;

   typedef enum logic [3:0] {
      S_IDLE     = 4'h0,
      S_RS_SDA   = 4'h1,
      S_RS_SCL   = 4'h2,
      S_ST_SDA   = 4'h3,
      S_BIT_LOW  = 4'h4,
      S_BIT_HIGH = 4'h5,
      S_HOLD     = 4'h6,
      S_SP_LOW   = 4'h7,
      S_SP_HIGH  = 4'h8,
      S_SP_SDA   = 4'h9
   } i2m_state_e;

endpackage : i2m_pkg

// file: logic/i2m_sync.sv
// Two-stage synchroniser for bus line levels.
// Assumes lines idle high, so both stages reset to one.
`timescale 1ns/1ps
module i2m_sync #(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            meta_q[i] <= i2m_pkg::SYNC_RST;
            q[i] <= i2m_pkg::SYNC_RST;
         end else begin
            meta_q[i] <= d[i];
            q[i] <= meta_q[i];
         end
      end
   end

endmodule : i2m_sync

// file: logic/i2m_timer.sv
// Half-period timer for SCL phases.
// Counts only while run is high; clr restarts it from zero.
`timescale 1ns/1ps
module i2m_timer (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clr,
   input wire logic run,
   output logic done
);

   logic [i2m_pkg::TMR_W-1:0] cnt_q;

   assign done = run && (cnt_q == i2m_pkg::HALF_LAST);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
      end else if (clr) begin
         cnt_q <= '0;
      end else if (run && !done) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

endmodule : i2m_timer

// file: verif/i2m_slave_model.sv
// Behavioural slave on the shared two-wire bus, the far side of the master.
// Assumes wired-AND line levels resolved by the bench, idle high.
`timescale 1ns/1ps
module i2m_slave_model #(
   parameter logic [6:0] OWN_ADDR = 7'h50
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic two_wire_power_off,
   input wire logic gc_accept,
   input wire logic stretch,
   input wire logic nack_writes,
   input wire logic [7:0] tx_byte,
   output logic scl_pull,
   output logic sda_pull,
   output logic [7:0] rx_byte,
   output logic master_nack
);
   int cnt;
   logic active, addr_ph, matched, rw;
   logic [7:0] sh, tx;

   initial begin
      {active, addr_ph, matched, rw, scl_pull, sda_pull, master_nack} = '0;
      cnt = 0;
      rx_byte = 8'h00;
   end

   // ----------------------------------------------------------------
   // Framing
   // ----------------------------------------------------------------
   always @(negedge sda) begin
      if (scl === 1'b1 && !two_wire_power_off) begin
         {active, addr_ph, matched, master_nack, sda_pull} = 5'h18;
         cnt = 0;
      end
   end
   always @(posedge sda) if (scl === 1'b1) begin
      active = 1'b0;
      sda_pull = 1'b0;
   end

   // Sample only on the rising clock edge; data changes only while low
   always @(posedge scl) if (active) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      else if (rw && !addr_ph) master_nack = sda;
      cnt++;
   end

   always @(negedge scl) if (active) begin
      if (cnt == 8 && addr_ph) begin
         matched = (sh[7:1] == OWN_ADDR) ||
            (sh == 8'h00 && gc_accept);
         rw = sh[0];
         sda_pull = matched;
      end else if (cnt == 8) begin
         if (matched && !rw) rx_byte = sh;
         sda_pull = matched && !rw && !nack_writes;
      end else if (cnt == 9) begin
         // Next read byte is the complement, so no input changes mid-packet
         tx = addr_ph ? tx_byte : ~tx;
         cnt = 0;
         addr_ph = 1'b0;
         sda_pull = matched && rw && !master_nack && !tx[7];
      end else if (cnt > 0 && matched && rw && !addr_ph) begin
         sda_pull = matched && !master_nack && !tx[7-cnt];
      end
   end

   // Clock stretching: hold SCL low after each falling edge
   always @(negedge scl) if (active && stretch) begin
      scl_pull = 1'b1;
      #3000;
      scl_pull = 1'b0;
   end
endmodule : i2m_slave_model

// file: verif/tb_two_wire_bus_framing.sv
// Self-checking bench for the two-wire bus master against a slave model.
// Assumes the master derives SCL from clk; no bench link clock is needed.
`timescale 1ns/1ps
module tb_two_wire_bus_framing;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic cmd_valid = 1'b0;
   i2m_pkg::i2m_cmd_s cmd = '0;
   i2m_pkg::i2m_rsp_s rsp;
   logic cmd_ready, rsp_valid, bus_busy, scl_o, scl_oe, sda_o, sda_oe;
   logic s_scl_pull, s_sda_pull, x_sda_pull = 1'b0;
   logic gc_accept = 1'b0, stretch = 1'b0, nack_writes = 1'b0;
   logic power_off = 1'b0;
   logic [7:0] rx_byte;
   logic master_nack;
   wire scl = (scl_oe ? scl_o : 1'b1) & ~s_scl_pull;
   wire sda = (sda_oe ? sda_o : 1'b1) & ~s_sda_pull & ~x_sda_pull;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;

   always #5 clk = ~clk;

   i2m_master u_i2m_master (.clk(clk), .reset_n(reset_n),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp(rsp), .bus_busy(bus_busy),
      .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));

   i2m_slave_model u_i2m_slave_model (.scl(scl), .sda(sda),
      .two_wire_power_off(power_off), .gc_accept(gc_accept),
      .stretch(stretch), .nack_writes(nack_writes), .tx_byte(8'hC3),
      .scl_pull(s_scl_pull), .sda_pull(s_sda_pull), .rx_byte(rx_byte),
      .master_nack(master_nack));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic close_out;
      if (err_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   task automatic check_eq(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check_eq

   // One command, held until taken, then wait for its response
   task automatic xfer(input logic st, sp, rd, ls, input logic [7:0] d);
      int n;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd = {st, sp, rd, ls, d};
      while (cmd_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      check_eq(16'(rsp_valid), 16'h0001);
   endtask : xfer

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_write;
      stretch = 1'b1;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA0);
      check_eq(16'(rsp.nack), 16'h0000);
      check_eq(16'(bus_busy), 16'h0001);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h3C);
      check_eq({rx_byte, rsp.data}, 16'h3C3C);
      check_eq(16'(rsp.nack), 16'h0000);
      nack_writes = 1'b1;
      xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'hA5);
      check_eq({rx_byte, 7'h00, rsp.nack}, 16'hA501);
      check_eq(16'(bus_busy), 16'h0000);
      {stretch, nack_writes} = 2'b00;
   endtask : t_write

   task automatic t_read;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA1);
      check_eq(16'(rsp.nack), 16'h0000);
      xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
      check_eq({rsp.data, 7'h00, master_nack}, 16'hC300);
      xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
      check_eq({rsp.data, 7'h00, master_nack}, 16'h3C01);
      check_eq(16'(bus_busy), 16'h0000);
   endtask : t_read

   task automatic t_nack_restart;
      power_off = 1'b1;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA0);
      check_eq(16'(rsp.nack), 16'h0001);
      power_off = 1'b0;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h66);
      check_eq(16'(rsp.nack), 16'h0001);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA0);
      check_eq({7'h00, bus_busy, 7'h00, rsp.nack}, 16'h0100);
      xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h81);
      check_eq(16'(rx_byte), 16'h0081);
   endtask : t_nack_restart

   task automatic t_special_addr;
      logic [7:0] bad [4] = '{8'h01, 8'hF0, 8'hF7, 8'hFE};
      foreach (bad[i]) begin
         xfer(1'b1, 1'b0, 1'b0, 1'b0, bad[i]);
         check_eq({rsp.refused, bus_busy}, 16'h0002);
      end
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      check_eq({rsp.nack, rsp.refused}, 16'h0002);
      gc_accept = 1'b1;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      check_eq({rsp.nack, rsp.refused}, 16'h0000);
      xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h42);
      check_eq(16'(rx_byte), 16'h0042);
      gc_accept = 1'b0;
   endtask : t_special_addr

   // Another master holds SDA low while this one sends a one
   task automatic t_arbitration;
      fork
         xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA0);
         begin
            wait (bus_busy === 1'b1);
            @(negedge scl);
            x_sda_pull = 1'b1;
         end
      join
      check_eq({rsp.arb_lost, scl_oe, sda_oe}, 16'h0004);
      @(negedge clk);
      x_sda_pull = 1'b0;
      repeat (10) @(negedge clk);
      check_eq(16'(bus_busy), 16'h0000);
   endtask : t_arbitration

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_count++;
         close_out();
      end
   end

   initial begin
      repeat (12) @(negedge clk);
      reset_n = 1'b1;
      t_write();
      t_read();
      t_nack_restart();
      t_special_addr();
      t_arbitration();
      close_out();
   end
endmodule : tb_two_wire_bus_framing
